// [bench/ddr2_command_power_state_decode_tb_top.sv]
// self-checking bench joining the controller end and the dram decoder over the link
`timescale 1ns/1ps
module ddr2_command_power_state_decode_tb_top;
  import ddr2_cmd_pkg::*;
  typedef struct packed {
    logic [2:0] stb; logic [1:0] bank; logic [13:0] addr; logic mask; logic [3:0] cmd; logic beat;
  } row_s;
  logic        clock, reset, req_valid, req_mask, req_power_down, req_self_refresh, req_term;
  logic [2:0]  req_strobes;
  logic [1:0]  req_bank;
  logic [13:0] req_addr;
  logic        req_ready_ff, dll_on_ff, burst_busy_ff, write_beat_ff, term_active_ff;
  logic        cmd_event_ff, beat_seen;
  logic [3:0]  last_cmd_ff, bank_open_ff;
  logic [1:0]  last_bank_ff;
  logic [13:0] last_row_ff, mode_reg_ff, ext_mode_reg1_ff;
  logic [9:0]  last_col_ff;
  logic [4:0]  power_state_ff;
  int          miscompares, samples_checked, cycles;
  // legal order: every bank is closed again before refresh and the mode loads
  row_s rows [13] = '{
    '{STB_ACT, 2'h1, 14'h3fff, 1'b0, CMD_ACT, 1'b0},
    '{STB_WR, 2'h1, 14'h0005, 1'b0, CMD_WR, 1'b1},
    '{STB_RD, 2'h1, 14'h0406, 1'b0, CMD_RDA, 1'b0},
    '{STB_ACT, 2'h2, 14'h0012, 1'b0, CMD_ACT, 1'b0},
    '{STB_WR, 2'h2, 14'h0407, 1'b1, CMD_WRA, 1'b0},
    '{STB_ACT, 2'h0, 14'h0001, 1'b0, CMD_ACT, 1'b0},
    '{STB_PRE, 2'h0, 14'h0000, 1'b0, CMD_PRE, 1'b0},
    '{STB_ACT, 2'h3, 14'h0002, 1'b0, CMD_ACT, 1'b0},
    '{STB_RD, 2'h3, 14'h0008, 1'b0, CMD_RD, 1'b0},
    '{STB_PRE, 2'h0, 14'h0400, 1'b0, CMD_PREA, 1'b0},
    '{STB_REF, 2'h0, 14'h0000, 1'b0, CMD_REF, 1'b0},
    '{STB_MRS, 2'h1, 14'h0044, 1'b0, CMD_MRS, 1'b0},
    '{STB_MRS, 2'h0, 14'h0032, 1'b0, CMD_MRS, 1'b0}};

  ddr2_link_if ddr2_link_if_i ();
  ddr2_controller_end ddr2_controller_end_i (.clock(clock), .reset(reset), .link(ddr2_link_if_i),
    .req_valid(req_valid), .req_strobes(req_strobes), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_power_down(req_power_down), .req_self_refresh(req_self_refresh),
    .req_term(req_term), .req_ready_ff(req_ready_ff));
  ddr2_command_power_state_decode ddr2_command_power_state_decode_i (.clock(clock),
    .reset(reset), .link(ddr2_link_if_i), .last_cmd_ff(last_cmd_ff), .last_bank_ff(last_bank_ff),
    .last_row_ff(last_row_ff), .last_col_ff(last_col_ff), .bank_open_ff(bank_open_ff),
    .power_state_ff(power_state_ff), .dll_on_ff(dll_on_ff), .burst_busy_ff(burst_busy_ff),
    .write_beat_ff(write_beat_ff), .mode_reg_ff(mode_reg_ff),
    .ext_mode_reg1_ff(ext_mode_reg1_ff), .term_active_ff(term_active_ff),
    .cmd_event_ff(cmd_event_ff));
  ddr2_link_asserts ddr2_link_asserts_i (.link_clk(ddr2_link_if_i.link_clk), .reset(reset),
    .clock_enable(ddr2_link_if_i.clock_enable), .chip_select_n(ddr2_link_if_i.chip_select_n),
    .row_strobe_n(ddr2_link_if_i.row_strobe_n), .column_strobe_n(ddr2_link_if_i.column_strobe_n),
    .write_enable_n(ddr2_link_if_i.write_enable_n), .addr(ddr2_link_if_i.addr),
    .last_cmd_ff(last_cmd_ff), .power_state_ff(power_state_ff),
    .burst_busy_ff(burst_busy_ff), .dll_on_ff(dll_on_ff));

  always #25 clock = ~clock;
  always @(posedge clock) if (write_beat_ff === 1'b1) beat_seen <= 1'b1;

  task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude

  // hold the request until taken, then wait for the decode and the burst tail
  task automatic issue(row_s r);
    int n;
    @(negedge clock);
    {req_strobes, req_bank, req_addr, req_mask} = {r.stb, r.bank, r.addr, r.mask};
    req_valid = 1'b1;
    beat_seen = 1'b0;
    for (n = 0; n < 64 && req_ready_ff !== 1'b1; n++) @(negedge clock);
    req_valid = 1'b0;
    for (n = 0; n < 64 && cmd_event_ff !== 1'b1; n++) @(negedge clock);
    repeat (16) @(negedge clock);
  endtask : issue

  task automatic wait_state(logic [4:0] s);
    for (int n = 0; n < 400 && power_state_ff !== s; n++) @(negedge clock);
    check("power_state", power_state_ff, s);
  endtask : wait_state

  always @(posedge clock) begin
    cycles++;
    // generous ceiling: the whole sequence needs under a thousand clocks
    if (cycles == 30000) begin
      miscompares++;
      conclude();
    end
  end

  initial begin
    {clock, reset, req_valid, req_mask, req_power_down, req_self_refresh, req_term} = 7'h20;
    {req_strobes, req_bank, req_addr, cycles, miscompares, samples_checked} = '0;
    // twelve clocks with the link clock held still; only the dram end's reset flops take reset without a link edge
    repeat (12) @(negedge clock);
    reset = 1'b0;
    repeat (12) @(negedge clock);
    check("power_state", power_state_ff, ST_IDLE);
    check("dll_on", dll_on_ff, 1'b1);
    check("bank_open", bank_open_ff, 4'h0);
    foreach (rows[i]) begin
      issue(rows[i]);
      check("last_cmd", last_cmd_ff, rows[i].cmd);
      check("write_beat", beat_seen, rows[i].beat);
      if (rows[i].stb inside {STB_ACT, STB_WR, STB_RD})
        check("bank", last_bank_ff, rows[i].bank);
      if (i == 0) check("row", last_row_ff, 14'h3fff);
      if (i == 0) check("bank_open", bank_open_ff, 4'h2);
      if (i == 1) check("col", last_col_ff, 10'h005);
    end
    check("bank_open", bank_open_ff, 4'h0);
    check("ext_mode_reg1", ext_mode_reg1_ff, 14'h0044);
    check("mode_reg", mode_reg_ff, 14'h0032);
    issue(rows[3]);
    req_power_down = 1'b1;
    wait_state(ST_APD);
    req_power_down = 1'b0;
    wait_state(ST_ACTIVE);
    issue(rows[9]);
    req_power_down = 1'b1;
    wait_state(ST_PPD);
    req_power_down = 1'b0;
    wait_state(ST_IDLE);
    req_term = 1'b1;
    repeat (40) @(negedge clock);
    check("term_active", term_active_ff, 1'b1);
    req_self_refresh = 1'b1;
    wait_state(ST_SREF);
    check("dll_on", dll_on_ff, 1'b0);
    check("term_active", term_active_ff, 1'b0);
    req_self_refresh = 1'b0;
    wait_state(ST_IDLE);
    check("dll_on", dll_on_ff, 1'b1);
    conclude();
  end
endmodule : ddr2_command_power_state_decode_tb_top

// [bench/ddr2_link_asserts.sv]
// concurrent checks on the dram link and the decoder's state outputs
`timescale 1ns/1ps
module ddr2_link_asserts
  import ddr2_cmd_pkg::*;
(
  input wire logic                  link_clk,
  input wire logic                  reset,
  input wire logic                  clock_enable,
  input wire logic                  chip_select_n,
  input wire logic                  row_strobe_n,
  input wire logic                  column_strobe_n,
  input wire logic                  write_enable_n,
  input wire logic [ADDR_WIDTH-1:0] addr,
  input wire logic [3:0]            last_cmd_ff,
  input wire logic [4:0]            power_state_ff,
  input wire logic                  burst_busy_ff,
  input wire logic                  dll_on_ff
);
  wire [2:0] strobes_now;
  assign strobes_now = {row_strobe_n, column_strobe_n, write_enable_n};

  default clocking @(posedge link_clk); endclocking
  default disable iff (reset);

  sequence issued(logic [2:0] s);
    clock_enable && $past(clock_enable) && !chip_select_n && strobes_now == s;
  endsequence
  sequence idle_cmd;
    chip_select_n || strobes_now == STB_NOP;
  endsequence
  sequence cke_fell;
    $past(clock_enable) && !clock_enable;
  endsequence
  sequence burst_run;
    burst_busy_ff ##1 burst_busy_ff ##1 !burst_busy_ff;
  endsequence

  // decoded code shows one or two link edges later, as the hand-over allows
  property decode(logic [2:0] s, logic [3:0] c);
    issued(s) |-> ##[1:2] last_cmd_ff == c;
  endproperty
  property decode_ap(logic [2:0] s, logic ap, logic [3:0] c);
    issued(s) ##0 addr[AP_BIT] == ap |-> ##[1:2] last_cmd_ff == c;
  endproperty

  act_decode_a: assert property (decode(STB_ACT, CMD_ACT))
    else $error("activate not decoded");
  ref_decode_a: assert property (decode(STB_REF, CMD_REF))
    else $error("refresh not decoded");
  mrs_decode_a: assert property (decode(STB_MRS, CMD_MRS))
    else $error("mode load not decoded");
  pre_one_a: assert property (decode_ap(STB_PRE, 1'b0, CMD_PRE))
    else $error("single precharge not decoded");
  pre_all_a: assert property (decode_ap(STB_PRE, 1'b1, CMD_PREA))
    else $error("precharge all not decoded");
  wr_plain_a: assert property (decode_ap(STB_WR, 1'b0, CMD_WR))
    else $error("write not decoded");
  wr_auto_a: assert property (decode_ap(STB_WR, 1'b1, CMD_WRA))
    else $error("write auto precharge not decoded");
  rd_plain_a: assert property (decode_ap(STB_RD, 1'b0, CMD_RD))
    else $error("read not decoded");
  rd_auto_a: assert property (decode_ap(STB_RD, 1'b1, CMD_RDA))
    else $error("read auto precharge not decoded");
  burst_whole_a: assert property ((issued(STB_WR) or issued(STB_RD)) |=> idle_cmd)
    else $error("burst interrupted by a command");
  burst_span_a: assert property ((issued(STB_WR) or issued(STB_RD)) |=> burst_run)
    else $error("burst did not run two link cycles");
  sref_entry_a: assert property (cke_fell ##0 !chip_select_n ##0 strobes_now == STB_REF
    |-> ##[1:2] power_state_ff == ST_SREF && !dll_on_ff)
    else $error("self refresh not entered");
  sref_exit_a: assert property (power_state_ff == ST_SREF && clock_enable
    |-> ##[1:2] power_state_ff != ST_SREF && dll_on_ff)
    else $error("self refresh not left");
  pd_idle_a: assert property (cke_fell ##0 idle_cmd ##0 power_state_ff == ST_IDLE
    |-> ##[1:2] power_state_ff == ST_PPD)
    else $error("precharge power-down not entered");
  pd_open_a: assert property (cke_fell ##0 idle_cmd ##0 power_state_ff == ST_ACTIVE
    |-> ##[1:2] power_state_ff == ST_APD)
    else $error("active power-down not entered");
endmodule : ddr2_link_asserts

// [design/ddr2_cmd_pkg.sv]
// constants shared by the dram command decoder and its controller end
package ddr2_cmd_pkg;
  localparam int ROW_WIDTH_X8   = 14;  // top address bit A13 on the eight-bit part
  localparam int ROW_WIDTH_X16  = 13;  // top address bit A12 on the sixteen-bit part
  localparam int ADDR_WIDTH     = 14;
  localparam int BANK_WIDTH     = 2;
  localparam int NUM_BANKS      = 4;
  localparam int AP_BIT         = 10;
  localparam int COL_WIDTH      = 10;
  localparam int EMR1_TERM_LO   = 2;
  localparam int EMR1_TERM_HI   = 6;
  localparam int BURST_LENGTH   = 4;
  localparam int BURST_BEATS    = BURST_LENGTH / 2;
  localparam int CKE_MIN_PULSE  = 3;
  localparam int SR_EXIT_READ   = 200;
  localparam int SR_EXIT_NONRD  = 10;
  localparam int MRD_CYCLES     = 2;
  localparam int LINK_DIV       = 1;
  localparam logic [1:0] MR_SEL_MODE = 2'h0;
  localparam logic [1:0] MR_SEL_EMR1 = 2'h1;
  localparam logic [ADDR_WIDTH-1:0] EMR1_RESET = 14'h0000;

  // command strobes ras_n, cas_n, we_n
  localparam logic [2:0] STB_MRS  = 3'h0;
  localparam logic [2:0] STB_REF  = 3'h1;
  localparam logic [2:0] STB_PRE  = 3'h2;
  localparam logic [2:0] STB_ACT  = 3'h3;
  localparam logic [2:0] STB_WR   = 3'h4;
  localparam logic [2:0] STB_RD   = 3'h5;
  localparam logic [2:0] STB_NOP  = 3'h7;

  typedef enum logic [3:0] {
    CMD_NONE = 4'h0, CMD_MRS = 4'h1, CMD_REF = 4'h2, CMD_PRE = 4'h3, CMD_PREA = 4'h4,
    CMD_ACT = 4'h5, CMD_WR = 4'h6, CMD_WRA = 4'h7, CMD_RD = 4'h8, CMD_RDA = 4'h9,
    CMD_SRE = 4'ha, CMD_SRX = 4'hb, CMD_PDE = 4'hc, CMD_PDX = 4'hd, CMD_ILL = 4'he
  } cmd_e;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'h01,
    ST_ACTIVE = 5'h02,
    ST_APD    = 5'h04,
    ST_PPD    = 5'h08,
    ST_SREF   = 5'h10
  } pwr_e;
endpackage : ddr2_cmd_pkg

// [design/ddr2_command_power_state_decode.sv]
// dram end: command decode, bank state and clock-enable power states
`timescale 1ns/1ps
// What this block does
// - illegal sequences decode as CMD_ILL, nothing re-initialises
// - decode command from strobes on rising edge
// - all strobes low loads selected mode register
// - activate, precharge one/all, refresh by bank
// - write decode, A10 adds auto precharge
// - read decode, A10 adds auto precharge
// - row field sized by part width
// - four-beat bursts always run to completion
// - self-refresh only requested with all banks idle
// - self-refresh exits on the first link edge sampling clock enable high
// - only nop/deselect while leaving self-refresh
// - controller waits SR_EXIT_READ after self-refresh before any command, none after power-down
// - power-down active or precharge by bank state
// - nop/deselect around every power-down transition
// - no power-down while operations are in progress
// - no refresh in power-down, controller limits it
// - clock enable held three edges per level
// - clock enable high during driver calibration
// - termination unavailable in self-refresh, valid in power-down
// - data mask high blocks coincident write data
// - only legal commands with clock enable high
// - mode load with banks idle, then wait
module ddr2_command_power_state_decode
  import ddr2_cmd_pkg::*;
#(
  parameter bit WIDE_PART = 1'b0
) (
  input  wire logic                  clock,
  input  wire logic                  reset,
  ddr2_link_if.dram                  link,
  output logic [3:0]                 last_cmd_ff,
  output logic [BANK_WIDTH-1:0]      last_bank_ff,
  output logic [ADDR_WIDTH-1:0]      last_row_ff,
  output logic [COL_WIDTH-1:0]       last_col_ff,
  output logic [NUM_BANKS-1:0]       bank_open_ff,
  output logic [4:0]                 power_state_ff,
  output logic                       dll_on_ff,
  output logic                       burst_busy_ff,
  output logic                       write_beat_ff,
  output logic [ADDR_WIDTH-1:0]      mode_reg_ff,
  output logic [ADDR_WIDTH-1:0]      ext_mode_reg1_ff,
  output logic                       term_active_ff,
  output logic                       cmd_event_ff
);
  // the sixteen-bit part has one row bit fewer
  localparam int ROW_WIDTH = WIDE_PART ? ROW_WIDTH_X16 : ROW_WIDTH_X8;

  // bank index to one-hot, used for activate and precharge
  function automatic logic [NUM_BANKS-1:0] bank_hot(input logic [BANK_WIDTH-1:0] b);
    bank_hot = NUM_BANKS'(1) << b;
  endfunction : bank_hot

  // the link clock stands still while reset is high, so reset is taken in
  // at once and let go over two link edges; only the second flop is read
  logic rst_meta_ff, rst_link_ff;
  always_ff @(posedge link.link_clk or posedge reset) begin
    if (reset) begin
      rst_meta_ff <= 1'b1;
      rst_link_ff <= 1'b1;
    end else begin
      rst_meta_ff <= 1'b0;
      rst_link_ff <= rst_meta_ff;
    end
  end

  logic cke_prev_ff;
  wire [2:0] strobes = {link.row_strobe_n, link.column_strobe_n, link.write_enable_n};
  wire       sel     = ~link.chip_select_n;
  wire       cke     = link.clock_enable;
  wire       idle_ok = (strobes == STB_NOP) | ~sel;
  wire       ap      = link.addr[AP_BIT];
  pwr_e      pstate_ff, nxt_pstate;
  cmd_e      dec;
  logic [NUM_BANKS-1:0] nxt_open;

  // exit from self-refresh is sampled: the state flop leaves ST_SREF on
  // the first link edge that sees clock enable high
  wire sref_asleep = (pstate_ff == ST_SREF) & ~cke;

  // unlisted patterns decode as illegal so a monitor can flag them
  always_comb begin
    dec = CMD_NONE;
    // clock enable low on both edges decodes nothing, so no refresh runs
    if (cke_prev_ff & cke) begin
      if (sel) begin
        case (strobes)
          STB_MRS: dec = CMD_MRS;
          STB_REF: dec = CMD_REF;
          STB_PRE: dec = ap ? CMD_PREA : CMD_PRE;
          STB_ACT: dec = CMD_ACT;
          STB_WR:  dec = ap ? CMD_WRA : CMD_WR;
          STB_RD:  dec = ap ? CMD_RDA : CMD_RD;
          STB_NOP: dec = CMD_NONE;
          default: dec = CMD_ILL;
        endcase
      end
    end else if (cke_prev_ff & ~cke) begin
      if (sel & (strobes == STB_REF)) dec = CMD_SRE;
      else if (idle_ok) dec = CMD_PDE;
      else dec = CMD_ILL;
    end else if (~cke_prev_ff & cke) begin
      if (!idle_ok) dec = CMD_ILL;
      else if (pstate_ff == ST_SREF) dec = CMD_SRX;
      else dec = CMD_PDX;
    end
  end

  // idle and active follow the bank bits, so a precharge or an auto
  // precharge brings the state back to idle without an event of its own
  always_comb begin
    nxt_pstate = pstate_ff;
    case (pstate_ff)
      ST_IDLE:   if (dec == CMD_SRE) nxt_pstate = ST_SREF;
                 else if (dec == CMD_PDE) nxt_pstate = ST_PPD;
                 else if (nxt_open != '0) nxt_pstate = ST_ACTIVE;
      ST_ACTIVE: if (dec == CMD_PDE) nxt_pstate = ST_APD;
                 else if (nxt_open == '0) nxt_pstate = ST_IDLE;
      ST_APD:    if (cke) nxt_pstate = ST_ACTIVE;
      ST_PPD:    if (cke) nxt_pstate = ST_IDLE;
      ST_SREF:   if (cke) nxt_pstate = ST_IDLE;
      default:   nxt_pstate = ST_IDLE;
    endcase
  end

  // bank bookkeeping
  // an auto precharge closes its bank only once the burst has run out
  logic [1:0]           beat_ff;
  logic                 ap_pending_ff;
  logic [BANK_WIDTH-1:0] ap_bank_ff;
  wire is_rw   = (dec == CMD_WR) | (dec == CMD_WRA) | (dec == CMD_RD) | (dec == CMD_RDA);
  wire is_wr   = (dec == CMD_WR) | (dec == CMD_WRA);
  wire burst_end = burst_busy_ff & (beat_ff == 2'(BURST_BEATS - 1));
  always_comb begin
    nxt_open = bank_open_ff;
    if (burst_end & ap_pending_ff) nxt_open = nxt_open & ~bank_hot(ap_bank_ff);
    case (dec)
      CMD_ACT:  nxt_open = nxt_open | bank_hot(link.bank_addr);
      CMD_PRE:  nxt_open = nxt_open & ~bank_hot(link.bank_addr);
      CMD_PREA: nxt_open = '0;
      default:  nxt_open = nxt_open;
    endcase
  end

  // bank address picks which mode register the opcode lands in
  wire ext_sel = link.bank_addr == MR_SEL_EMR1;
  always_ff @(posedge link.link_clk) begin
    if (rst_link_ff) begin
      cke_prev_ff      <= 1'b0;
      pstate_ff        <= ST_IDLE;
      bank_open_ff     <= '0;
      last_cmd_ff      <= 4'h0;
      last_bank_ff     <= '0;
      last_row_ff      <= '0;
      last_col_ff      <= '0;
      mode_reg_ff      <= '0;
      ext_mode_reg1_ff <= EMR1_RESET;
      burst_busy_ff    <= 1'b0;
      beat_ff          <= 2'h0;
      ap_pending_ff    <= 1'b0;
      ap_bank_ff       <= '0;
      write_beat_ff    <= 1'b0;
      cmd_event_ff     <= 1'b0;
      dll_on_ff        <= 1'b1;
      term_active_ff   <= 1'b0;
      power_state_ff   <= 5'h01;
    end else begin
      cke_prev_ff    <= cke;
      pstate_ff      <= sref_asleep ? ST_SREF : nxt_pstate;
      power_state_ff <= sref_asleep ? 5'(ST_SREF) : 5'(nxt_pstate);
      bank_open_ff   <= nxt_open;
      cmd_event_ff   <= dec != CMD_NONE;
      dll_on_ff      <= nxt_pstate != ST_SREF;
      if (dec != CMD_NONE) begin
        last_cmd_ff  <= 4'(dec);
        last_bank_ff <= link.bank_addr;
      end
      if (dec == CMD_ACT) last_row_ff <= ADDR_WIDTH'(link.addr[ROW_WIDTH-1:0]);
      if (is_rw) last_col_ff <= link.addr[COL_WIDTH-1:0];
      if (dec == CMD_MRS) begin
        if (link.bank_addr == MR_SEL_MODE) mode_reg_ff <= link.addr;
        if (ext_sel) ext_mode_reg1_ff <= link.addr;
      end
      // mask is sampled per beat; a high sample blocks that beat and the rest of the burst
      // a started burst always runs its beats out
      if (is_rw & ~burst_busy_ff) begin
        burst_busy_ff <= 1'b1;
        beat_ff       <= 2'h0;
        ap_pending_ff <= (dec == CMD_WRA) | (dec == CMD_RDA);
        ap_bank_ff    <= link.bank_addr;
        write_beat_ff <= is_wr & ~link.data_mask;
      end else if (burst_busy_ff) begin
        beat_ff       <= beat_ff + 2'h1;
        burst_busy_ff <= ~burst_end;
        if (burst_end) ap_pending_ff <= 1'b0;
        write_beat_ff <= write_beat_ff & ~burst_end & ~link.data_mask;
      end else begin
        write_beat_ff <= 1'b0;
      end
      // termination ignored in self-refresh, honoured elsewhere if enabled
      term_active_ff <= link.termination_ctrl & (nxt_pstate != ST_SREF) &
                        (ext_mode_reg1_ff[EMR1_TERM_LO] | ext_mode_reg1_ff[EMR1_TERM_HI]);
    end
  end
endmodule : ddr2_command_power_state_decode

// [design/ddr2_controller_end.sv]
// controller end: drives link clock and legal command sequences
`timescale 1ns/1ps
module ddr2_controller_end
  import ddr2_cmd_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  reset,
  ddr2_link_if.controller            link,
  input  wire logic                  req_valid,
  input  wire logic [2:0]            req_strobes,
  input  wire logic [BANK_WIDTH-1:0] req_bank,
  input  wire logic [ADDR_WIDTH-1:0] req_addr,
  input  wire logic                  req_mask,
  input  wire logic                  req_power_down,
  input  wire logic                  req_self_refresh,
  input  wire logic                  req_term,
  output logic                       req_ready_ff
);
  logic                  clk_ff;
  logic                  div_ff;
  logic                  cke_ff;
  logic [7:0]            wait_ff;
  logic [1:0]            hold_ff;
  logic [NUM_BANKS-1:0]  open_ff;
  logic                  in_sref_ff;
  logic                  cs_n_ff, ras_ff, cas_ff, we_ff, dm_ff, odt_ff;
  logic [BANK_WIDTH-1:0] ba_ff;
  logic [ADDR_WIDTH-1:0] a_ff;

  assign link.link_clk         = clk_ff;
  assign link.clock_enable     = cke_ff;
  assign link.chip_select_n    = cs_n_ff;
  assign {link.row_strobe_n, link.column_strobe_n, link.write_enable_n} = {ras_ff, cas_ff, we_ff};
  assign link.bank_addr        = ba_ff;
  assign link.addr             = a_ff;
  assign link.data_mask        = dm_ff;
  assign link.termination_ctrl = odt_ff;

  // commands change only on the falling half so the dram samples them stable
  wire edge_now  = div_ff & clk_ff;
  wire cke_held  = hold_ff == 2'(CKE_MIN_PULSE - 1);
  wire quiet     = wait_ff == 8'h00;
  wire all_idle  = open_ff == '0;
  wire want_low  = req_power_down | (req_self_refresh & all_idle);
  wire is_rd     = req_strobes == STB_RD;
  wire is_mrs    = req_strobes == STB_MRS;
  wire issue     = req_valid & cke_ff & quiet & (~is_mrs | all_idle);

  always_ff @(posedge clock) begin
    if (reset) begin
      clk_ff <= 1'b0; div_ff <= 1'b0; cke_ff <= 1'b0; wait_ff <= 8'h00;
      hold_ff <= 2'h0; open_ff <= '0; in_sref_ff <= 1'b0; req_ready_ff <= 1'b0;
      cs_n_ff <= 1'b1; ras_ff <= 1'b1; cas_ff <= 1'b1; we_ff <= 1'b1;
      ba_ff <= '0; a_ff <= '0; dm_ff <= 1'b1; odt_ff <= 1'b0;
    end else begin
      div_ff <= ~div_ff;
      if (div_ff) clk_ff <= ~clk_ff;
      odt_ff <= req_term & ~in_sref_ff;
      req_ready_ff <= 1'b0;
      if (edge_now) begin
        {cs_n_ff, ras_ff, cas_ff, we_ff} <= {1'b1, STB_NOP};
        dm_ff <= 1'b1;
        if (!cke_held) hold_ff <= hold_ff + 2'h1;
        if (wait_ff != 8'h00) wait_ff <= wait_ff - 8'h01;
        // no calibration mode is ever entered, so cke never drops in one
        if (cke_ff & cke_held & quiet & want_low) begin
          cke_ff  <= 1'b0;
          hold_ff <= 2'h0;
          if (req_self_refresh & all_idle) begin
            {cs_n_ff, ras_ff, cas_ff, we_ff} <= {1'b0, STB_REF};
            in_sref_ff <= 1'b1;
          end
        end else if (~cke_ff & cke_held & ~want_low) begin
          cke_ff     <= 1'b1;
          hold_ff    <= 2'h0;
          wait_ff    <= in_sref_ff ? 8'(SR_EXIT_READ) : 8'h00;
          in_sref_ff <= 1'b0;
        end else if (issue & ~want_low & (~is_rd | quiet)) begin
          {cs_n_ff, ras_ff, cas_ff, we_ff} <= {1'b0, req_strobes};
          ba_ff <= req_bank;
          a_ff  <= req_addr;
          dm_ff <= req_mask;
          req_ready_ff <= 1'b1;
          if (is_mrs) wait_ff <= 8'(MRD_CYCLES);
          if (req_strobes == STB_ACT) open_ff <= open_ff | (NUM_BANKS'(1) << req_bank);
          if (req_strobes == STB_PRE)
            open_ff <= req_addr[AP_BIT] ? '0 : open_ff & ~(NUM_BANKS'(1) << req_bank);
          if (req_strobes[2] & ~req_strobes[1]) wait_ff <= 8'(BURST_BEATS);
        end
      end
    end
  end
endmodule : ddr2_controller_end

// [design/ddr2_link_if.sv]
// link between controller end and dram command decoder
`timescale 1ns/1ps
interface ddr2_link_if;
  import ddr2_cmd_pkg::*;
  logic                  link_clk;
  logic                  clock_enable;
  logic                  chip_select_n;
  logic                  row_strobe_n;
  logic                  column_strobe_n;
  logic                  write_enable_n;
  logic [BANK_WIDTH-1:0] bank_addr;
  logic [ADDR_WIDTH-1:0] addr;
  logic                  data_mask;
  logic                  termination_ctrl;

  modport controller (
    output link_clk, clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
    output write_enable_n, bank_addr, addr, data_mask, termination_ctrl
  );
  modport dram (
    input link_clk, clock_enable, chip_select_n, row_strobe_n, column_strobe_n,
    input write_enable_n, bank_addr, addr, data_mask, termination_ctrl
  );
endinterface : ddr2_link_if
